// *** hw/smb_consts.svh ***
// constants for the two-wire bus control and slave receive block
`ifndef SMB_CONSTS_SVH
`define SMB_CONSTS_SVH

`define SMB_CTRL_ADDR       8'hc0
`define SMB_CTRL_RESET      8'h00
`define SMB_BIT_MASTER      7
`define SMB_BIT_TRANSMITTER_INDICATOR      6
`define SMB_BIT_BEGIN       5
`define SMB_BIT_HALT        4
`define SMB_BIT_ACKNOWLEDGE_REQUEST_FLAG       3
`define SMB_BIT_ARB         2
`define SMB_BIT_ACK         1
`define SMB_BIT_IRQ         0
`define SMB_CLK_NS          10
`define SMB_COND_HOLD_NS    4000
`define SMB_COND_HOLD_CYC   ((`SMB_COND_HOLD_NS + `SMB_CLK_NS - 1) / `SMB_CLK_NS)
`define SMB_TMR_W           10
`define SMB_BUF_DEPTH       2

`endif

// *** hw/smb_pkg.sv ***
// types for the two-wire bus control and slave receive block
package smb_pkg;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_WAIT,
        ST_ACK,
        ST_IGNORE,
        ST_MSTART,
        ST_MHOLD,
        ST_MSTOP
    } smb_state_t;
    typedef logic [7:0] smb_byte_t;
endpackage : smb_pkg

// *** hw/smb_ctrl.sv ***
// two-wire bus control register and slave receiver sequencing
`include "smb_consts.svh"

module smb_ctrl (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // special-function register port
    input  wire logic [7:0]       sfr_addr,
    input  wire logic             sfr_wr,
    input  wire smb_pkg::smb_byte_t sfr_wdata,
    input  wire logic             sfr_bit_wr,
    input  wire logic [7:0]       sfr_bit_addr,
    input  wire logic             sfr_bit_val,
    output smb_pkg::smb_byte_t    sfr_rdata,
    // data register write strobe
    input  wire logic             data_wr,
    // configuration
    input  wire logic             slave_event_mask,
    input  wire logic             auto_acknowledge_enable,
    input  wire logic [6:0]       slave_address_match_value,
    input  wire logic [6:0]       slave_address_match_mask,
    // received bytes
    output logic                  rx_valid,
    output smb_pkg::smb_byte_t    rx_data,
    input  wire logic             rx_ready,
    // bus pins, open drain
    input  wire logic             scl_i,
    output logic                  scl_o,
    output logic                  scl_oe,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oe
);
    import smb_pkg::*;

    localparam int SMB_START_BOUND = 2 * `SMB_COND_HOLD_CYC + 4;

    smb_state_t          state_reg, state_next;
    logic                master_reg, transmitter_indicator_reg, sta_reg, sta_req_reg, sto_reg;
    logic                acknowledge_request_flag_reg, arb_reg, ack_reg, si_reg;
    logic                scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    logic                scl_rise, scl_fall, start_det, stop_det;
    logic                bus_free_reg, is_addr_reg, ack_drive_reg, si_after_reg;
    logic                pend_reg, stall;
    logic [3:0]          bitcnt_reg;
    smb_byte_t           shift_reg, rdata_reg;
    logic [`SMB_TMR_W-1:0] tmr_reg;
    logic [7:0]          sw_we, sw_val;
    logic                ctrl_hit, bit_hit, si_adv, addr_match, tmr_done;
    logic                ev_si, ev_acknowledge_request_flag, ev_stop, ev_arb, ev_mon, ev_moff, ev_start, ev_push;
    logic                ack_drive_next, scl_oe_reg, sda_oe_reg;
    smb_byte_t           buf_mem [`SMB_BUF_DEPTH];
    logic                wp_reg, rp_reg;
    logic [1:0]          cnt_reg;

    // byte writes and single-bit writes decode to one enable per bit
    assign ctrl_hit = sfr_wr && (sfr_addr == `SMB_CTRL_ADDR);
    assign bit_hit  = sfr_bit_wr && (sfr_bit_addr[7:3] == 5'(`SMB_CTRL_ADDR >> 3));
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bit
            assign sw_we[gi]  = ctrl_hit || (bit_hit && sfr_bit_addr[2:0] == 3'(gi));
            assign sw_val[gi] = ctrl_hit ? sfr_wdata[gi] : sfr_bit_val;
        end
    endgenerate

    // pins are sampled twice before use; the third stage only finds edges
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
        end
    end
    assign scl_rise  = scl_s2 && !scl_s3;
    assign scl_fall  = !scl_s2 && scl_s3;
    assign start_det = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
    assign stop_det  = scl_s2 && scl_s3 && sda_s2 && !sda_s3;

    assign addr_match = ((shift_reg[7:1] ^ slave_address_match_value)
                        & slave_address_match_mask) == 7'h00;
    assign si_adv   = si_reg && sw_we[`SMB_BIT_IRQ] && !sw_val[`SMB_BIT_IRQ] && !ev_si;
    assign tmr_done = tmr_reg == `SMB_TMR_W'(2 * `SMB_COND_HOLD_CYC - 1);
    assign stall    = pend_reg && (cnt_reg == 2'(`SMB_BUF_DEPTH));

    always_comb begin
        state_next     = state_reg;
        ack_drive_next = ack_drive_reg;
        ev_si          = 1'b0;
        ev_acknowledge_request_flag       = 1'b0;
        ev_stop        = 1'b0;
        ev_arb         = 1'b0;
        ev_mon         = 1'b0;
        ev_moff        = 1'b0;
        ev_start       = 1'b0;
        ev_push        = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (sta_req_reg && bus_free_reg && scl_s2 && sda_s2) begin
                    state_next = ST_MSTART;
                end else if (sta_req_reg && !bus_free_reg) begin
                    ev_arb = 1'b1;
                    ev_si  = 1'b1;
                end
            end
            ST_ADDR, ST_DATA: begin
                if (scl_fall && bitcnt_reg == 4'h8) begin
                    if (state_reg == ST_DATA) begin
                        ev_push = 1'b1;
                        if (auto_acknowledge_enable) begin
                            ack_drive_next = ack_reg;
                            state_next     = ST_ACK;
                        end else begin
                            ev_si      = 1'b1;
                            ev_acknowledge_request_flag   = 1'b1;
                            state_next = ST_WAIT;
                        end
                    end else if (!slave_event_mask && addr_match && !shift_reg[0]) begin
                        if (auto_acknowledge_enable) begin
                            ack_drive_next = 1'b1;
                            state_next     = ST_ACK;
                        end else begin
                            ev_si      = 1'b1;
                            ev_acknowledge_request_flag   = 1'b1;
                            state_next = ST_WAIT;
                        end
                    end else begin
                        state_next = ST_IGNORE;
                    end
                end
            end
            ST_WAIT: begin
                if (si_adv) begin
                    // ack choice and flag clear often arrive in one byte write
                    ack_drive_next = sw_we[`SMB_BIT_ACK] ? sw_val[`SMB_BIT_ACK] : ack_reg;
                    state_next     = ST_ACK;
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    ev_si          = auto_acknowledge_enable;
                    ack_drive_next = 1'b0;
                    state_next     = (is_addr_reg && !ack_drive_reg) ? ST_IGNORE : ST_DATA;
                end
            end
            ST_MSTART: begin
                if (tmr_done) begin
                    ev_mon     = 1'b1;
                    ev_si      = 1'b1;
                    state_next = ST_MHOLD;
                end
            end
            ST_MHOLD: begin
                if (!si_reg && sta_req_reg) begin
                    state_next = ST_MSTART;
                end else if (!si_reg && sto_reg) begin
                    state_next = ST_MSTOP;
                end
            end
            ST_MSTOP: begin
                if (tmr_done) begin
                    ev_moff    = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default: state_next = state_reg;
        endcase
        // conditions seen on the wire override the byte sequence outside ST_MSTART, ST_MHOLD and ST_MSTOP
        if (state_reg != ST_MSTART && state_reg != ST_MSTOP && state_reg != ST_MHOLD) begin
            if (start_det) begin
                ev_start       = 1'b1;
                ack_drive_next = 1'b0;
                state_next     = ST_ADDR;
            end else if (stop_det) begin
                ev_stop    = state_reg inside {ST_DATA, ST_WAIT, ST_ACK};
                ev_si      = ev_stop;
                state_next = ST_IDLE;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg     <= ST_IDLE;
            ack_drive_reg <= 1'b0;
        end else begin
            state_reg     <= state_next;
            ack_drive_reg <= ack_drive_next;
        end
    end

    // bit counter, shifter and address-byte marker
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bitcnt_reg  <= 4'h0;
            shift_reg   <= 8'h00;
            is_addr_reg <= 1'b0;
        end else if (ev_start || (state_reg == ST_ACK && scl_fall)) begin
            bitcnt_reg  <= 4'h0;
            is_addr_reg <= ev_start;
        end else if (scl_rise && bitcnt_reg != 4'h8
                     && (state_reg == ST_ADDR || state_reg == ST_DATA)) begin
            bitcnt_reg <= bitcnt_reg + 4'h1;
            shift_reg  <= {shift_reg[6:0], sda_s2};
        end
    end

    // condition timing: start releases SDA for half, then drives it for half; stop drives SDA throughout
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmr_reg <= '0;
        end else if (state_next != state_reg) begin
            tmr_reg <= '0;
        end else if (state_reg == ST_MSTART || state_reg == ST_MSTOP) begin
            tmr_reg <= tmr_reg + `SMB_TMR_W'(1);
        end
    end

    // bus is free after a stop, busy after a start not generated here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_free_reg <= 1'b1;
        end else if (start_det && state_reg != ST_MSTART) begin
            bus_free_reg <= 1'b0;
        end else if (stop_det || ev_moff) begin
            bus_free_reg <= 1'b1;
        end
    end

    // control register bits; hardware sets win over software clears
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            si_reg <= 1'b0;
        end else if (ev_si) begin
            si_reg <= 1'b1;
        end else if (sw_we[`SMB_BIT_IRQ]) begin
            si_reg <= sw_val[`SMB_BIT_IRQ];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            master_reg <= 1'b0;
            arb_reg    <= 1'b0;
        end else begin
            if (ev_mon) begin
                master_reg <= 1'b1;
            end else if (ev_moff) begin
                master_reg <= 1'b0;
            end
            if (ev_arb) begin
                arb_reg <= 1'b1;
            end else if (ev_mon) begin
                arb_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sta_reg     <= 1'b0;
            sta_req_reg <= 1'b0;
        end else begin
            if (ev_start || ev_mon) begin
                sta_reg <= 1'b1;
            end else if (sw_we[`SMB_BIT_BEGIN]) begin
                sta_reg <= sw_val[`SMB_BIT_BEGIN];
            end
            if (ev_mon || ev_arb) begin
                sta_req_reg <= 1'b0;
            end else if (sw_we[`SMB_BIT_BEGIN]) begin
                sta_req_reg <= sw_val[`SMB_BIT_BEGIN];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sto_reg <= 1'b0;
        end else if (ev_stop) begin
            sto_reg <= 1'b1;
        end else if (ev_moff) begin
            sto_reg <= 1'b0;
        end else if (sw_we[`SMB_BIT_HALT]) begin
            sto_reg <= sw_val[`SMB_BIT_HALT];
        end
    end

    // acknowledge request follows the manual-mode handshake only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acknowledge_request_flag_reg <= 1'b0;
            ack_reg   <= 1'b0;
        end else begin
            if (ev_acknowledge_request_flag) begin
                acknowledge_request_flag_reg <= 1'b1;
            end else if (si_adv || ev_stop || ev_start) begin
                acknowledge_request_flag_reg <= 1'b0;
            end
            if (sw_we[`SMB_BIT_ACK]) begin
                ack_reg <= sw_val[`SMB_BIT_ACK];
            end
        end
    end

    // a data write during reception turns the slave into a transmitter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            transmitter_indicator_reg <= 1'b0;
        end else if (ev_start || stop_det) begin
            transmitter_indicator_reg <= 1'b0;
        end else if (data_wr && state_reg inside {ST_DATA, ST_WAIT, ST_ACK}) begin
            transmitter_indicator_reg <= 1'b1;
        end
    end

    // read data: one cycle after the address is presented
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= `SMB_CTRL_RESET;
        end else begin
            rdata_reg <= (sfr_addr == `SMB_CTRL_ADDR)
                ? {master_reg, transmitter_indicator_reg, sta_reg, sto_reg,
                   acknowledge_request_flag_reg, arb_reg, ack_reg, si_reg}
                : 8'h00;
        end
    end
    assign sfr_rdata = rdata_reg;

    // two-entry receive buffer; a full buffer stretches the clock so no byte is lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_reg <= 1'b0;
            wp_reg   <= 1'b0;
            rp_reg   <= 1'b0;
            cnt_reg  <= 2'h0;
        end else begin
            if (ev_push) begin
                pend_reg <= 1'b1;
            end else if (pend_reg && (cnt_reg != 2'(`SMB_BUF_DEPTH) || rx_ready)) begin
                pend_reg <= 1'b0;
            end
            if (pend_reg && (cnt_reg != 2'(`SMB_BUF_DEPTH) || rx_ready)) begin
                wp_reg <= !wp_reg;
            end
            if (rx_valid && rx_ready) begin
                rp_reg <= !rp_reg;
            end
            cnt_reg <= cnt_reg + 2'(pend_reg && (cnt_reg != 2'(`SMB_BUF_DEPTH) || rx_ready))
                               - 2'(rx_valid && rx_ready);
        end
    end
    always_ff @(posedge clk) begin
        if (pend_reg && (cnt_reg != 2'(`SMB_BUF_DEPTH) || rx_ready)) begin
            buf_mem[wp_reg] <= shift_reg;
        end
    end
    assign rx_valid = cnt_reg != 2'h0;
    assign rx_data  = buf_mem[rp_reg];

    // pin drivers are registered to keep glitches off the wire
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else begin
            scl_oe_reg <= si_reg || stall || state_reg == ST_MHOLD
                          || (state_reg == ST_MSTOP && !tmr_reg[`SMB_TMR_W-1] && tmr_reg == '0);
            sda_oe_reg <= (state_reg == ST_ACK && ack_drive_reg)
                          || (state_reg == ST_MSTART && tmr_reg >= `SMB_TMR_W'(`SMB_COND_HOLD_CYC))
                          || state_reg == ST_MSTOP;
        end
    end
    assign scl_oe = scl_oe_reg;
    assign sda_oe = sda_oe_reg;
    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;

    // checks
    scl_hold_a: assert property (@(posedge clk) disable iff (rst) si_reg |=> scl_oe)
        else $error("clock not held while interrupt pending");
    irq_clear_a: assert property (@(posedge clk) disable iff (rst)
        si_adv |=> !si_reg)
        else $error("interrupt flag not cleared");
    irq_force_a: assert property (@(posedge clk) disable iff (rst)
        sw_we[0] && sw_val[0] |=> si_reg)
        else $error("forced interrupt missing");
    role_ro_a: assert property (@(posedge clk) disable iff (rst)
        sw_we[7] && sw_val[7] && !ev_mon && !ev_moff |=> master_reg == $past(master_reg))
        else $error("role bit changed by write");
    manual_req_a: assert property (@(posedge clk) disable iff (rst)
        ev_acknowledge_request_flag |=> acknowledge_request_flag_reg && si_reg && state_reg == ST_WAIT)
        else $error("manual ack request missing");
    auto_irq_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_ACK && scl_fall && auto_acknowledge_enable && !start_det && !stop_det
        |=> si_reg ##1 !sda_oe)
        else $error("auto ack interrupt misplaced");
    ack_drive_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_ACK && ack_drive_reg |=> sda_oe)
        else $error("ack not driven");
    ignore_mute_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_IGNORE && !sw_we[0] |=> !$rose(si_reg))
        else $error("interrupt while address ignored");
    stop_exit_a: assert property (@(posedge clk) disable iff (rst)
        ev_stop |=> sto_reg && si_reg && state_reg == ST_IDLE)
        else $error("stop not recorded");
    start_gen_a: assert property (@(posedge clk) disable iff (rst)
        $rose(state_reg == ST_MSTART) |-> ##[1:SMB_START_BOUND] master_reg)
        else $error("start not completed");
    tx_switch_a: assert property (@(posedge clk) disable iff (rst)
        data_wr && state_reg == ST_DATA && !start_det && !stop_det |=> transmitter_indicator_reg)
        else $error("transmitter mode not entered");
    cover_addr_c: cover property (@(posedge clk) disable iff (rst)
        state_reg == ST_ADDR ##[1:200] state_reg == ST_WAIT);
    cover_data_c: cover property (@(posedge clk) disable iff (rst) ev_push ##[1:400] ev_push);
    cover_stall_c: cover property (@(posedge clk) disable iff (rst) stall);
    cover_master_c: cover property (@(posedge clk) disable iff (rst) ev_moff);
endmodule : smb_ctrl

// *** tb/smb_host_model.sv ***
// behavioural bus master on the two open-drain lines
module smb_host_model (
    // bench clock, used only to keep line edges mid-cycle
    input  wire logic clk,
    // resolved lines
    input  wire logic scl,
    input  wire logic sda,
    // pull-downs, 1 pulls low
    output logic      scl_low,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // data moves only while clock low; slave may stretch the low phase
    task automatic put_bit(input logic b, output logic r);
        sda_low = !b;
        #40;
        scl_low = 1'b0;
        wait (scl === 1'b1);
        r = sda;
        #40;
        // mid-cycle edge leaves the slave time to stretch before release
        @(negedge clk);
        scl_low = 1'b1;
    endtask : put_bit
    task automatic start;
        @(negedge clk);
        sda_low = 1'b1;
        #40;
        scl_low = 1'b1;
    endtask : start
    task automatic xfer(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) put_bit(d[i], r);
        put_bit(1'b1, r);
        ack = !r;
    endtask : xfer
    task automatic stop;
        sda_low = 1'b1;
        #40;
        scl_low = 1'b0;
        wait (scl === 1'b1);
        #40;
        sda_low = 1'b0;
        #80;
    endtask : stop
endmodule : smb_host_model

// *** tb/smb_ctrl_tb_top.sv ***
// self-checking bench for the bus control and slave receive block
module smb_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import smb_pkg::*;
    logic      clk, rst, sfr_wr, sfr_bit_wr, sfr_bit_val, data_wr, auto_ack, rx_ready;
    logic [7:0] sfr_addr, sfr_bit_addr;
    smb_byte_t sfr_wdata, sfr_rdata, rx_data;
    logic      rx_valid, scl_oe, sda_oe, scl_low, sda_low, a0, a1;
    int        fail_count, cmp_count;
    // pull-ups: a released line reads high
    wire logic scl = !(scl_oe | scl_low);
    wire logic sda = !(sda_oe | sda_low);
    smb_ctrl u_dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr),
        .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata), .data_wr(data_wr),
        .slave_event_mask(1'b0), .auto_acknowledge_enable(auto_ack),
        .slave_address_match_value(7'h2a), .slave_address_match_mask(7'h7f),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .scl_i(scl),
        .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
    smb_host_model u_host (.clk(clk), .scl(scl), .sda(sda), .scl_low(scl_low),
        .sda_low(sda_low));
    task chk(input smb_byte_t seen, input smb_byte_t exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input smb_byte_t v);
        @(posedge clk);
        sfr_wr <= 1'b1;
        sfr_wdata <= v;
        @(posedge clk);
        sfr_wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : wr
    task bw(input logic [7:0] a, input logic v);
        @(posedge clk);
        sfr_bit_wr <= 1'b1;
        sfr_bit_addr <= a;
        sfr_bit_val <= v;
        @(posedge clk);
        sfr_bit_wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : bw
    task wait_irq;
        for (int i = 0; i < 3000 && sfr_rdata[0] !== 1'b1; i++) @(posedge clk);
    endtask : wait_irq
    task pop(input smb_byte_t exp);
        chk({7'h0, rx_valid}, 8'h01);
        chk(rx_data, exp);
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
        @(posedge clk);
    endtask : pop
    task t_regs;
        chk(sfr_rdata, 8'h00);
        @(posedge clk);
        sfr_addr <= 8'h10;
        repeat (3) @(posedge clk);
        chk(sfr_rdata, 8'h00);
        sfr_addr <= 8'hc0;
        wr(8'hcc);
        chk(sfr_rdata, 8'h00);
        bw(8'hc0, 1'b1);
        chk(sfr_rdata, 8'h01);
        chk({7'h0, scl_oe}, 8'h01);
        bw(8'hc0, 1'b0);
        chk(sfr_rdata, 8'h00);
    endtask : t_regs
    task t_manual;
        fork
            begin
                u_host.start;
                u_host.xfer({7'h2a, 1'b0}, a0);
                u_host.xfer(8'h5a, a1);
                u_host.stop;
            end
            begin
                wait_irq;
                chk(sfr_rdata & 8'hcd, 8'h09);
                wr(8'h02);
                wait_irq;
                chk(sfr_rdata & 8'hcd, 8'h09);
                wr(8'h02);
                wait_irq;
                chk(sfr_rdata & 8'h11, 8'h11);
                wr(8'h00);
            end
        join
        chk({7'h0, a0}, 8'h01);
        chk({7'h0, a1}, 8'h01);
    endtask : t_manual
    task t_auto;
        auto_ack <= 1'b1;
        wr(8'h02);
        fork
            begin
                u_host.start;
                u_host.xfer({7'h2a, 1'b0}, a0);
                u_host.xfer(8'h3c, a1);
                u_host.stop;
            end
            begin
                wait_irq;
                chk(sfr_rdata & 8'hcd, 8'h01);
                wr(8'h02);
                wait_irq;
                @(posedge clk);
                data_wr <= 1'b1;
                @(posedge clk);
                data_wr <= 1'b0;
                repeat (2) @(posedge clk);
                chk(sfr_rdata & 8'h40, 8'h40);
                wr(8'h02);
                wait_irq;
                wr(8'h00);
            end
        join
        chk({7'h0, a0}, 8'h01);
        chk({7'h0, a1}, 8'h01);
        u_host.start;
        u_host.xfer({7'h11, 1'b0}, a0);
        u_host.xfer(8'hff, a1);
        u_host.stop;
        chk({7'h0, a0}, 8'h00);
        chk({7'h0, sfr_rdata[0]}, 8'h00);
        pop(8'h5a);
        pop(8'h3c);
        chk({7'h0, rx_valid}, 8'h00);
    endtask : t_auto
    task t_master;
        bw(8'hc5, 1'b1);
        wait_irq;
        chk(sfr_rdata & 8'h81, 8'h81);
        chk({7'h0, scl_oe}, 8'h01);
        wr(8'h10);
        // stop phase lasts 800 cycles
        repeat (1000) @(posedge clk);
        chk(sfr_rdata & 8'h90, 8'h00);
    endtask : t_master
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst, sfr_wr, sfr_bit_wr, sfr_bit_val, data_wr, auto_ack, rx_ready} = 7'h40;
        {sfr_addr, sfr_bit_addr, sfr_wdata} = {8'hc0, 16'h0};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_regs;
        t_manual;
        t_auto;
        t_master;
        report_and_stop;
    end
    initial begin
        #200000;
        fail_count++;
        report_and_stop;
    end
endmodule : smb_ctrl_tb_top
